// *** logic/cct_timing.sv ***
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module cct_timing
	import cct_pkg::*;
(
	// Clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// APB slave
	input  wire logic [AW-1:0] paddr,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [DW-1:0] pwdata,
	output logic      [DW-1:0] prdata,
	output logic               pready,
	output logic               pslverr,
	// External cycle trigger pin
	input  wire logic          cyc_trig_pin,
	// Camera, light and sequence status
	output logic               cam_trigger,
	output logic               strobe_out,
	output logic               seq_active
);
	logic [CTRL_W-1:0] ctrl_reg;
	logic [TW-1:0]     pulse_width_reg;
	logic [TW-1:0]     recovery_reg;
	logic [TW-1:0]     frame_reg;
	logic [TW-1:0]     offset_reg;
	logic [TW-1:0]     strobe_w_reg;
	logic [CW-1:0]     seqn_reg;
	logic [CW-1:0]     lost_reg;
	logic [CW-1:0]     done_reg;
	logic [DW-1:0]     prdata_reg;
	logic              pready_reg;
	logic              pslverr_reg;
	logic              sync1_reg;
	logic              sync2_reg;
	logic              sync3_reg;
	logic              seq_active_reg;
	logic              seq_done_reg;
	logic              stop_pend_reg;
	cct_cyc_t          state_reg;
	logic [PRW-1:0]    presc_reg;
	logic [LW-1:0]     elapsed_reg;
	logic [LW-1:0]     cur_len_reg;
	logic [TW-1:0]     cur_ton;
	logic [TW-1:0]     cur_pw;
	logic [TW-1:0]     cur_son;
	logic [TW-1:0]     cur_sw;
	logic              cam_trigger_reg;
	logic              strobe_out_reg;

	logic              access;
	logic              wr_en;
	logic [DW-1:0]     rd_mux;
	logic              cmd_wr;
	logic              start_seq_cmd;
	logic              stop_seq_cmd;
	logic              start_cyc_cmd;
	logic              trig_evt;
	logic              end_now;
	logic              go_ok;
	logic              cy_start;
	logic              cy_end;
	logic              seq_go;
	logic [LW-1:0]     cycle_len;
	logic [TW-1:0]     trig_on;
	logic [TW-1:0]     strobe_on;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	function automatic logic addr_ok(input logic [AW-1:0] a);
		case (a)
			A_CTRL, A_CMD, A_PW, A_REC, A_FRAME, A_SOFF,
			A_SW, A_SEQN, A_STAT, A_LOST, A_CLEN: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	endfunction : addr_ok

	function automatic logic in_win(input logic [LW-1:0] t, input logic [TW-1:0] on,
		input logic [TW-1:0] w);
		in_win = (t >= LW'(on)) && (t < LW'(on) + LW'(w));
	endfunction : in_win

	cct_cycle_len u_len (
		.pulse_width   (pulse_width_reg),
		.recovery      (recovery_reg),
		.frame_period  (frame_reg),
		.strobe_width  (strobe_w_reg),
		.strobe_offset (offset_reg),
		.overlap_enable(ctrl_reg[B_OVL]),
		.cycle_len     (cycle_len),
		.trig_on       (trig_on),
		.strobe_on     (strobe_on)
	);

	// The answer comes one cycle into the access phase; writes land on that edge.
	assign access = psel & penable & ~pready_reg;
	assign wr_en = psel & penable & pready_reg & pwrite & addr_ok(paddr);
	assign cmd_wr = wr_en && (paddr == A_CMD);
	assign start_seq_cmd = cmd_wr && pwdata[B_START_SEQ];
	assign stop_seq_cmd = cmd_wr && pwdata[B_STOP_SEQ];
	assign start_cyc_cmd = cmd_wr && pwdata[B_START_CYC];

	always_comb begin
		rd_mux = '0;
		case (paddr)
			A_CTRL: rd_mux = DW'(ctrl_reg);
			A_PW: rd_mux = DW'(pulse_width_reg);
			A_REC: rd_mux = DW'(recovery_reg);
			A_FRAME: rd_mux = DW'(frame_reg);
			A_SOFF: rd_mux = DW'(offset_reg);
			A_SW: rd_mux = DW'(strobe_w_reg);
			A_SEQN: rd_mux = DW'(seqn_reg);
			A_STAT: rd_mux = DW'({done_reg, stop_pend_reg, state_reg, seq_active_reg});
			A_LOST: rd_mux = DW'(lost_reg);
			A_CLEN: rd_mux = DW'(cur_len_reg);
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
		end else begin
			pready_reg <= access;
			pslverr_reg <= access & ~addr_ok(paddr);
			prdata_reg <= (access & ~pwrite) ? rd_mux : '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= CTRL_RST;
			pulse_width_reg <= PW_RST;
			recovery_reg <= REC_RST;
			frame_reg <= FRAME_RST;
			offset_reg <= SOFF_RST;
			strobe_w_reg <= SW_RST;
			seqn_reg <= SEQN_RST;
		end else if (wr_en) begin
			case (paddr)
				A_CTRL: ctrl_reg <= pwdata[CTRL_W-1:0];
				A_PW: pulse_width_reg <= pwdata[TW-1:0];
				A_REC: recovery_reg <= pwdata[TW-1:0];
				A_FRAME: frame_reg <= pwdata[TW-1:0];
				A_SOFF: offset_reg <= pwdata[TW-1:0];
				A_SW: strobe_w_reg <= pwdata[TW-1:0];
				A_SEQN: seqn_reg <= pwdata[CW-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
		end else begin
			sync1_reg <= cyc_trig_pin;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	assign trig_evt = ~ctrl_reg[B_SELF] & ((sync2_reg & ~sync3_reg) | start_cyc_cmd);
	// Fixed length ends the sequence at the boundary after the last cycle.
	assign end_now = seq_active_reg && (state_reg == CY_WAIT) &&
		(stop_pend_reg || (ctrl_reg[B_FIXED] && done_reg >= seqn_reg));
	assign go_ok = seq_active_reg && (state_reg == CY_WAIT) && !end_now;
	// A cycle starts after expiry on an accepted trigger, or with no trigger when self-triggered.
	assign cy_start = go_ok && (ctrl_reg[B_SELF] || trig_evt);
	assign cy_end = (state_reg == CY_RUN) && (elapsed_reg >= cur_len_reg);
	assign seq_go = !seq_active_reg && ctrl_reg[B_RUN] &&
		(start_seq_cmd || (ctrl_reg[B_SIMM] && !seq_done_reg));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_active_reg <= 1'b0;
			seq_done_reg <= 1'b0;
			done_reg <= '0;
		end else begin
			if (end_now) begin
				seq_active_reg <= 1'b0;
			end else if (seq_go) begin
				seq_active_reg <= 1'b1;
			end
			if (end_now) begin
				seq_done_reg <= 1'b1;
			end else if (!ctrl_reg[B_RUN]) begin
				seq_done_reg <= 1'b0;
			end
			if (seq_go) begin
				done_reg <= '0;
			end else if (cy_start && done_reg != CNT_MAX) begin
				done_reg <= done_reg + CW'(1);
			end
		end
	end

	// A stop request set in the same cycle as the boundary clear survives.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_pend_reg <= 1'b0;
		end else if (seq_active_reg && (stop_seq_cmd || !ctrl_reg[B_RUN])) begin
			stop_pend_reg <= 1'b1;
		end else if (end_now || seq_go) begin
			stop_pend_reg <= 1'b0;
		end
	end

	// Rejected triggers are counted; an increment wins over a clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lost_reg <= '0;
		end else if (trig_evt && !go_ok) begin
			if (lost_reg != CNT_MAX) begin
				lost_reg <= lost_reg + CW'(1);
			end
		end else if (wr_en && paddr == A_LOST) begin
			lost_reg <= '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= CY_WAIT;
			presc_reg <= '0;
			elapsed_reg <= '0;
			cur_len_reg <= LEN_MIN;
			cur_ton <= '0;
			cur_pw <= '0;
			cur_son <= '0;
			cur_sw <= '0;
		end else begin
			case (state_reg)
				CY_WAIT: begin
					if (cy_start) begin
						state_reg <= CY_RUN;
						presc_reg <= '0;
						elapsed_reg <= '0;
						// Computed length taken at every start.
						cur_len_reg <= cycle_len;
						cur_ton <= trig_on;
						cur_pw <= pulse_width_reg;
						cur_son <= strobe_on;
						cur_sw <= strobe_w_reg;
					end
				end
				CY_RUN: begin
					if (cy_end) begin
						state_reg <= CY_WAIT;
					end else if (presc_reg == PRESC_LAST) begin
						presc_reg <= '0;
						elapsed_reg <= elapsed_reg + LW'(1);
					end else begin
						presc_reg <= presc_reg + PRW'(1);
					end
				end
				default: state_reg <= CY_WAIT;
			endcase
		end
	end

	// Trigger window is the pulse width; strobe window follows the offset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cam_trigger_reg <= 1'b0;
			strobe_out_reg <= 1'b0;
		end else begin
			cam_trigger_reg <= (state_reg == CY_RUN) && !cy_end && in_win(elapsed_reg, cur_ton, cur_pw);
			strobe_out_reg <= (state_reg == CY_RUN) && !cy_end && in_win(elapsed_reg, cur_son, cur_sw);
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign cam_trigger = cam_trigger_reg;
	assign strobe_out = strobe_out_reg;
	assign seq_active = seq_active_reg;

	a_trig_recovery: assert property (cy_start |=>
		cur_len_reg >= $past(LW'(pulse_width_reg) + LW'(recovery_reg)))
		else $error("cycle shorter than width plus recovery");
	a_readout_gap: assert property (cy_start |=> cur_len_reg >= $past(LW'(frame_reg)))
		else $error("cycle shorter than frame period");
	a_edges_inside: assert property (state_reg == CY_RUN |->
		cur_len_reg >= LW'(cur_ton) + LW'(cur_pw) && cur_len_reg >= LW'(cur_son) + LW'(cur_sw))
		else $error("pulse edge outside cycle");
	a_pulse_width: assert property ($fell(cam_trigger_reg) |->
		$past(elapsed_reg) == LW'(cur_ton) + LW'(cur_pw))
		else $error("trigger fell at wrong time");
	a_strobe_offset: assert property ($rose(strobe_out_reg) |->
		$past(elapsed_reg) == LW'(cur_son))
		else $error("strobe rose at wrong offset");
	a_early_gap: assert property (cy_start && offset_reg[TW-1] |=>
		cur_len_reg > $past(LW'(pulse_width_reg) + LW'(trig_on)))
		else $error("trigger gap not above strobe lead");
	a_late_strobe: assert property (cy_start && !offset_reg[TW-1] &&
		pulse_width_reg != '0 |-> ##2 cam_trigger_reg)
		else $error("trigger not high at cycle start");
	a_early_strobe: assert property (cy_start && offset_reg[TW-1] &&
		strobe_w_reg != '0 |-> ##2 strobe_out_reg)
		else $error("strobe not high at cycle start");
	a_seq_length: assert property (state_reg == CY_WAIT && seq_active_reg &&
		ctrl_reg[B_FIXED] && done_reg >= seqn_reg |=> !seq_active_reg)
		else $error("sequence did not stop after count");
	a_lost_count: assert property (trig_evt && !go_ok && lost_reg != CNT_MAX |=>
		lost_reg == $past(lost_reg) + CW'(1))
		else $error("lost trigger not counted");
	a_cycle_reload: assert property (cy_start |-> state_reg == CY_WAIT ##1
		(cur_len_reg == $past(cycle_len) && elapsed_reg == '0 && state_reg == CY_RUN))
		else $error("timer not reloaded at start");
endmodule : cct_timing
`default_nettype wire

// *** logic/cct_pkg.sv ***
`default_nettype none
package cct_pkg;
	localparam int AW = 8;
	localparam int DW = 32;
	localparam int TW = 24;
	localparam int LW = 26;
	localparam int CW = 24;
	localparam int CTRL_W = 5;
	localparam int CMD_W = 3;
	localparam int PRW = 6;

	localparam int CLK_NS = 25;
	localparam int US_NS = 1000;
	localparam int CLKS_PER_US = US_NS / CLK_NS;
	localparam logic [PRW-1:0] PRESC_LAST = PRW'(CLKS_PER_US - 1);
	localparam logic [LW-1:0] LEN_MIN = 26'h0000001;

	localparam logic [AW-1:0] A_CTRL = 8'h00;
	localparam logic [AW-1:0] A_CMD = 8'h04;
	localparam logic [AW-1:0] A_PW = 8'h08;
	localparam logic [AW-1:0] A_REC = 8'h0C;
	localparam logic [AW-1:0] A_FRAME = 8'h10;
	localparam logic [AW-1:0] A_SOFF = 8'h14;
	localparam logic [AW-1:0] A_SW = 8'h18;
	localparam logic [AW-1:0] A_SEQN = 8'h1C;
	localparam logic [AW-1:0] A_STAT = 8'h20;
	localparam logic [AW-1:0] A_LOST = 8'h24;
	localparam logic [AW-1:0] A_CLEN = 8'h28;

	localparam int B_RUN = 0;
	localparam int B_SELF = 1;
	localparam int B_FIXED = 2;
	localparam int B_SIMM = 3;
	localparam int B_OVL = 4;
	localparam int B_START_SEQ = 0;
	localparam int B_STOP_SEQ = 1;
	localparam int B_START_CYC = 2;

	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	localparam logic [TW-1:0] PW_RST = 24'h00000A;
	localparam logic [TW-1:0] REC_RST = 24'h000001;
	localparam logic [TW-1:0] FRAME_RST = 24'h000064;
	localparam logic [TW-1:0] SOFF_RST = 24'h000000;
	localparam logic [TW-1:0] SW_RST = 24'h00000A;
	localparam logic [CW-1:0] SEQN_RST = 24'h000001;
	localparam logic [CW-1:0] CNT_MAX = 24'hFFFFFF;

	typedef enum logic [0:0] {
		CY_WAIT = 1'b0,
		CY_RUN  = 1'b1
	} cct_cyc_t;
endpackage : cct_pkg
`default_nettype wire

// *** logic/cct_cycle_len.sv ***
`timescale 1ns/10ps
`default_nettype none
module cct_cycle_len
	import cct_pkg::*;
(
	// Settings in microseconds
	input  wire logic [TW-1:0] pulse_width,
	input  wire logic [TW-1:0] recovery,
	input  wire logic [TW-1:0] frame_period,
	input  wire logic [TW-1:0] strobe_width,
	input  wire logic [TW-1:0] strobe_offset,
	input  wire logic          overlap_enable,
	// Derived cycle shape
	output logic      [LW-1:0] cycle_len,
	output logic      [TW-1:0] trig_on,
	output logic      [TW-1:0] strobe_on
);
	logic          neg;
	logic [TW-1:0] mag;
	logic [LW-1:0] c_rec;
	logic [LW-1:0] c_rd;
	logic [LW-1:0] c_trg;
	logic [LW-1:0] c_str;
	logic [LW-1:0] c_early;

	function automatic logic [LW-1:0] max2(input logic [LW-1:0] a, input logic [LW-1:0] b);
		max2 = (a > b) ? a : b;
	endfunction : max2

	assign neg = strobe_offset[TW-1];
	assign mag = neg ? (~strobe_offset + TW'(1)) : strobe_offset;
	assign trig_on = neg ? mag : '0;
	assign strobe_on = neg ? '0 : mag;

	assign c_rec = LW'(pulse_width) + LW'(recovery);
	// Readouts may not overlap; without overlap exposure adds to readout.
	assign c_rd = overlap_enable ? LW'(frame_period) : LW'(pulse_width) + LW'(frame_period);
	// Both pulses end inside the cycle.
	assign c_trg = LW'(trig_on) + LW'(pulse_width);
	assign c_str = LW'(strobe_on) + LW'(strobe_width);
	// Gap between triggers must exceed the strobe lead.
	assign c_early = neg ? LW'(pulse_width) + LW'(mag) + LEN_MIN : '0;

	assign cycle_len = max2(max2(max2(c_rec, c_rd), max2(c_trg, c_str)), max2(c_early, LEN_MIN));
endmodule : cct_cycle_len
`default_nettype wire

// *** tb/cct_cam_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module cct_cam_model (
	// Clock, reset and trigger count clear
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic clr,
	// Camera trigger and strobe light inputs
	input  wire logic cam_trigger,
	input  wire logic strobe_out,
	// Measured pulse shape in clocks
	output int        n_trig,
	output int        width,
	output int        gap,
	output int        s_off
);
	int   now;
	int   t_cam;
	int   t_strb;
	logic cam_q;
	logic strb_q;

	assign s_off = t_strb - t_cam;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			now    <= 0;
			t_cam  <= 0;
			t_strb <= 0;
			cam_q  <= 1'b0;
			strb_q <= 1'b0;
			n_trig <= 0;
			width  <= 0;
			gap    <= 0;
		end else begin
			now    <= now + 1;
			cam_q  <= cam_trigger;
			strb_q <= strobe_out;
			if (clr) begin
				n_trig <= 0;
			end else if (cam_trigger && !cam_q) begin
				n_trig <= n_trig + 1;
				gap    <= now - t_cam;
				t_cam  <= now;
			end
			// Exposure length seen by the camera.
			if (!cam_trigger && cam_q) begin
				width <= now - t_cam;
			end
			if (strobe_out && !strb_q) begin
				t_strb <= now;
			end
		end
	end
endmodule : cct_cam_model
`default_nettype wire

// *** tb/camera_cycle_timing_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module camera_cycle_timing_tb_top;
	import cct_pkg::*;
	logic          pclk;
	logic          presetn;
	logic          psel, penable, pwrite, cyc_trig_pin, clr;
	logic [AW-1:0] paddr;
	logic [DW-1:0] pwdata, prdata, rd;
	logic          pready, pslverr, cam_trigger, strobe_out, seq_active, er;
	int            errors, n_compared, n_trig, width, gap, s_off;
	logic [AW-1:0] ra[9] = '{A_CTRL, A_PW, A_REC, A_FRAME, A_SOFF, A_SW, A_SEQN, A_LOST, A_CLEN};
	logic [DW-1:0] rv[9] = '{DW'(CTRL_RST), DW'(PW_RST), DW'(REC_RST), DW'(FRAME_RST),
		DW'(SOFF_RST), DW'(SW_RST), DW'(SEQN_RST), 32'h0, 32'h1};
	// Rows: width, recovery, frame period, offset, overlap, expected length.
	// Third row is an early strobe; rows four and five; row six.
	int            cs[6][6] = '{'{2, 3, 4, 0, 1, 5}, '{2, 3, 4, 1, 1, 5}, '{2, 3, 4, -3, 1, 6},
		'{2, 3, 10, 0, 1, 10}, '{2, 3, 10, 0, 0, 12}, '{4, 3, 2, 0, 1, 7}};

	cct_timing uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .cyc_trig_pin, .cam_trigger, .strobe_out, .seq_active);
	cct_cam_model cam (.pclk, .presetn, .clr, .cam_trigger, .strobe_out, .n_trig, .width, .gap,
		.s_off);

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_compared++;
		if (got !== ex) begin
			errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got);
		end
	endtask : chk

	task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
		n_compared++;
		if (got < lo || got > hi) begin
			errors++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask : chk_rng

	task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) chk("pready", 32'h1, 32'h0);
	endtask : apb

	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rchk(input string nm, input logic [AW-1:0] a, input logic [DW-1:0] ex);
		apb(1'b0, a, 32'h0);
		chk(nm, ex, rd);
		chk("pslverr", 32'h0, {31'h0, er});
	endtask : rchk

	task automatic waitfor(input logic v, input int lim);
		int n;
		n = 0;
		while (seq_active !== v && n < lim) begin
			@(posedge pclk);
			n++;
		end
		chk("seq_active", {31'h0, v}, {31'h0, seq_active});
	endtask : waitfor

	task automatic pin_pulse;
		@(posedge pclk);
		cyc_trig_pin <= 1'b1;
		repeat (3) @(posedge pclk);
		cyc_trig_pin <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask : pin_pulse

	task automatic run_case(input int pw, input int rec, input int fr, input int d, input int ovl,
		input int len);
		wr(A_CTRL, 32'h0);
		wr(A_PW, 32'(pw));
		wr(A_REC, 32'(rec));
		wr(A_FRAME, 32'(fr));
		wr(A_SOFF, 32'(d));
		wr(A_SW, 32'h1);
		wr(A_SEQN, 32'h2);
		clr <= 1'b1;
		wr(A_CTRL, 32'h0F | (32'(ovl) << 4));
		clr <= 1'b0;
		waitfor(1'b1, 100);
		waitfor(1'b0, 3000);
		repeat (2) @(posedge pclk);
		chk("trigger count", 32'h2, n_trig);
		chk("trigger width", pw * 40, width);
		chk("strobe offset", d * 40, s_off);
		chk_rng("trigger gap", len * 40, len * 40 + 3, gap);
		chk("outputs at end", 32'h0, 32'({cam_trigger, strobe_out}));
		rchk("cycle length", A_CLEN, 32'(len));
		$display("test case width %0d offset %0d length %0d done", pw, d, len);
	endtask : run_case

	initial begin
		#1_000_000;
		errors++;
		$display("watchdog expired");
		test_done();
	end

	initial begin
		presetn      = 1'b0;
		psel         = 1'b0;
		penable      = 1'b0;
		pwrite       = 1'b0;
		paddr        = '0;
		pwdata       = '0;
		cyc_trig_pin = 1'b0;
		clr          = 1'b0;
		errors       = 0;
		n_compared   = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ra[i]) rchk("reset value", ra[i], rv[i]);
		apb(1'b0, 8'h2C, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		wr(A_CLEN, 32'h5);
		rchk("length read only", A_CLEN, 32'h1);
		$display("test defaults done");
		foreach (cs[i]) run_case(cs[i][0], cs[i][1], cs[i][2], cs[i][3], cs[i][4], cs[i][5]);
		clr <= 1'b1;
		wr(A_CTRL, 32'h1);
		wr(A_LOST, 32'h0);
		clr <= 1'b0;
		pin_pulse();
		rchk("lost count", A_LOST, 32'h1);
		wr(A_CMD, 32'h1);
		waitfor(1'b1, 20);
		wr(A_CMD, 32'h4);
		rchk("status running", A_STAT, 32'hB);
		repeat (10) @(posedge pclk);
		pin_pulse();
		repeat (400) @(posedge pclk);
		chk("trigger count", 32'h1, n_trig);
		rchk("lost count", A_LOST, 32'h2);
		pin_pulse();
		chk("trigger count", 32'h2, n_trig);
		wr(A_CMD, 32'h2);
		rchk("status stopping", A_STAT, 32'h17);
		waitfor(1'b0, 400);
		rchk("lost count", A_LOST, 32'h2);
		wr(A_LOST, 32'h0);
		rchk("lost cleared", A_LOST, 32'h0);
		$display("test lost triggers done");
		test_done();
	end
endmodule : camera_cycle_timing_tb_top
`default_nettype wire
